// File: dsm_map.svh
// Operation
// - Overload monitoring uses the rated current in mA and stays inactive unless it is below both the peak limit and the maximum current.
// - The rated current and the current feedback are treated as root-mean-square values.
// - The maximum current may flow for no longer than the configured duration in ms before the limit drops to the rated current.
// - The computed overload value is compared with a threshold in mA to select the maximum or the rated current as limit.
// - The momentary rms current limit applied by the limiter is readable.
// - The overload status reads 0 when monitoring is inactive and 1 when active.
// - The torque target counts as met only while actual torque lies within a symmetric band of configured half-width around the target.
// - A half-width of all ones switches torque monitoring off and the target-reached bit is never set.
// - The torque must stay inside the band for the configured dwell in ms before target reached is signalled.
// - In velocity mode statusword bit 13 is set when the speed deviation magnitude exceeds the maximum slippage.
// - The slippage error is flagged only after the deviation has lasted longer than the slippage delay in ms.
// - With a slippage reaction configured, each raised slippage error also appends an error history entry.
// - Overload monitoring is enabled only with nonzero rated current and duration and a maximum current above 1000.
// - In open loop with monitoring enabled the limit is the smallest of rated, maximum and peak current.
`ifndef DSM_MAP_SVH
`define DSM_MAP_SVH
// ==========================================
// Register addresses
`define DSM_A_BAND_HALFW  16'h203d
`define DSM_A_BAND_DWELL  16'h203e
`define DSM_A_SLIP_DELAY  16'h203f
`define DSM_A_RATED       16'h2380
`define DSM_A_MAX_DUR     16'h2381
`define DSM_A_THRESHOLD   16'h2382
`define DSM_A_CALC        16'h2383
`define DSM_A_LIMIT       16'h2384
`define DSM_A_OL_STATUS   16'h2385
`define DSM_A_PEAK        16'h2386
`define DSM_A_MAXCUR      16'h2387
`define DSM_A_MAX_SLIP    16'h2388
`define DSM_A_CTRL        16'h2389
`define DSM_A_STATUSWORD  16'h238a
`define DSM_A_ERR_COUNT   16'h238b
// ==========================================
// Fields and reset values
`define DSM_CTRL_VEL      0
`define DSM_CTRL_OPEN     1
`define DSM_CTRL_REACT    2
`define DSM_SW_TREACH     10
`define DSM_SW_SLIP       13
`define DSM_BAND_OFF      16'hffff
`define DSM_MAXCUR_MIN    32'h0000_03e8
`define DSM_SLIP_DLY_RST  16'h0064
`define DSM_BAND_RST      16'h0000
`define DSM_DWELL_RST     16'h0000
`define DSM_W32_RST       32'h0000_0000
// ==========================================
// Timing
`define DSM_MS_NS         1000000
`define DSM_CLK_NS        100
`endif

// File: dsm_pkg.sv
package dsm_pkg;
   // ==========================================
   // Top-level state
   typedef struct packed {
      logic [15:0] div;
      logic        tick;
      logic [31:0] rated;
      logic [31:0] dur;
      logic [31:0] thr;
      logic [31:0] calc;
      logic [31:0] limit;
      logic [31:0] peak;
      logic [31:0] maxc;
      logic [31:0] max_slip;
      logic [15:0] halfw;
      logic [15:0] tdwell;
      logic [15:0] sdelay;
      logic [2:0]  ctrl;
      logic        active;
      logic        slip_prev;
      logic        elog;
      logic [15:0] err_cnt;
      logic [31:0] rdata;
   } dsm_top_s;
endpackage

// File: dsm_dwell.sv
`timescale 1ns/1ps
module dsm_dwell #(
   parameter int W      = 16,
   parameter bit STRICT = 1'b0
) (
   input  wire logic         clock_i,
   input  wire logic         nrst_i,
   input  wire logic         tick_i,
   input  wire logic         cond_i,
   input  wire logic [W-1:0] limit_i,
   output logic              done_o
);
   typedef struct packed {
      logic [W-1:0] cnt;
      logic         done;
   } dsm_dwell_s;

   dsm_dwell_s q;
   dsm_dwell_s d;

   // ==========================================
   // Dwell counter
   always_comb begin
      d = q;
      if (!cond_i) begin
         d.cnt = '0;
      end else if (tick_i && (q.cnt != {W{1'b1}})) begin
         d.cnt = q.cnt + 1'b1;
      end
      d.done = cond_i && (STRICT ? (q.cnt > limit_i) : (q.cnt >= limit_i));
   end

   always_ff @(posedge clock_i or negedge nrst_i) begin
      if (!nrst_i) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   assign done_o = q.done;

   // ==========================================
   // Checks
   a_dwell_drop: assert property (@(posedge clock_i) disable iff (!nrst_i)
      !cond_i |=> !done_o && q.cnt == '0)
      else $error("dwell not restarted after condition drop");
   a_dwell_count: assert property (@(posedge clock_i) disable iff (!nrst_i)
      done_o |-> $past(cond_i) && (STRICT ? $past(q.cnt) > $past(limit_i)
                                          : $past(q.cnt) >= $past(limit_i)))
      else $error("dwell done before limit reached");
endmodule

// File: dsm_top.sv
// The implementer's own choice: the plain strobed port.
`timescale 1ns/1ps
`include "dsm_map.svh"
module dsm_top #(
   parameter int MS_CYCLES = `DSM_MS_NS / `DSM_CLK_NS
) (
   input  wire logic        clock_i,
   input  wire logic        nrst_i,
   input  wire logic [15:0] addr_i,
   input  wire logic [31:0] wr_data_i,
   input  wire logic        wr_i,
   input  wire logic        rd_i,
   output logic      [31:0] rd_data_o,
   input  wire logic [31:0] current_ma_i,
   input  wire logic [15:0] torque_act_i,
   input  wire logic [15:0] torque_tgt_i,
   input  wire logic [31:0] speed_act_i,
   input  wire logic [31:0] speed_cmd_i,
   output logic      [31:0] current_limit_o,
   output logic             ol_active_o,
   output logic             torque_reached_o,
   output logic             slip_error_o,
   output logic             error_log_o
);
   dsm_pkg::dsm_top_s q;
   dsm_pkg::dsm_top_s d;

   logic        ol_en;
   logic        over_rated;
   logic [31:0] excess;
   logic [31:0] deficit;
   logic [32:0] calc_sum;
   logic [31:0] min_mp;
   logic [31:0] min3;
   logic        dur_done;
   logic [16:0] tq_diff;
   logic [16:0] tq_abs;
   logic        tq_in;
   logic [32:0] sp_diff;
   logic [32:0] sp_abs;
   logic        sp_over;
   logic        tq_done;
   logic        sp_done;
   logic [15:0] sw;

   // ==========================================
   // Combinational helpers
   always_comb begin
      ol_en = (q.rated != '0) && (q.dur != '0) && (q.maxc > `DSM_MAXCUR_MIN)
              && (q.rated < q.peak) && (q.rated < q.maxc);
      over_rated = current_ma_i > q.rated;
      excess     = over_rated ? current_ma_i - q.rated : '0;
      deficit    = over_rated ? '0 : q.rated - current_ma_i;
      calc_sum   = {1'b0, q.calc} + {1'b0, excess};
      min_mp     = (q.maxc < q.peak) ? q.maxc : q.peak;
      min3       = (q.rated < min_mp) ? q.rated : min_mp;
      tq_diff = {torque_act_i[15], torque_act_i} - {torque_tgt_i[15], torque_tgt_i};
      tq_abs  = tq_diff[16] ? 17'(-tq_diff) : tq_diff;
      tq_in   = (tq_abs <= {1'b0, q.halfw}) && (q.halfw != `DSM_BAND_OFF);
      sp_diff = {speed_act_i[31], speed_act_i} - {speed_cmd_i[31], speed_cmd_i};
      sp_abs  = sp_diff[32] ? 33'(-sp_diff) : sp_diff;
      sp_over = q.ctrl[`DSM_CTRL_VEL] && (sp_abs > {1'b0, q.max_slip});
      sw = '0;
      sw[`DSM_SW_TREACH] = tq_done;
      sw[`DSM_SW_SLIP]   = sp_done;
   end

   // ==========================================
   // Dwell timers
   dsm_dwell #(
      .W      (32),
      .STRICT (1'b0)
   ) u_dur (
      .clock_i (clock_i),
      .nrst_i  (nrst_i),
      .tick_i  (q.tick),
      .cond_i  (q.active && over_rated),
      .limit_i (q.dur),
      .done_o  (dur_done)
   );

   dsm_dwell #(
      .W      (16),
      .STRICT (1'b0)
   ) u_torque (
      .clock_i (clock_i),
      .nrst_i  (nrst_i),
      .tick_i  (q.tick),
      .cond_i  (tq_in),
      .limit_i (q.tdwell),
      .done_o  (tq_done)
   );

   dsm_dwell #(
      .W      (16),
      .STRICT (1'b1)
   ) u_slip (
      .clock_i (clock_i),
      .nrst_i  (nrst_i),
      .tick_i  (q.tick),
      .cond_i  (sp_over),
      .limit_i (q.sdelay),
      .done_o  (sp_done)
   );

   // ==========================================
   // Next state
   always_comb begin
      d = q;
      // Millisecond time base
      if (q.div >= 16'(MS_CYCLES - 1)) begin
         d.div  = '0;
         d.tick = 1'b1;
      end else begin
         d.div  = q.div + 16'h0001;
         d.tick = 1'b0;
      end
      // Register writes
      if (wr_i) begin
         case (addr_i)
            `DSM_A_BAND_HALFW: d.halfw    = wr_data_i[15:0];
            `DSM_A_BAND_DWELL: d.tdwell   = wr_data_i[15:0];
            `DSM_A_SLIP_DELAY: d.sdelay   = wr_data_i[15:0];
            `DSM_A_RATED:      d.rated    = wr_data_i;
            `DSM_A_MAX_DUR:    d.dur      = wr_data_i;
            `DSM_A_THRESHOLD:  d.thr      = wr_data_i;
            `DSM_A_CALC:       d.calc     = wr_data_i;
            `DSM_A_PEAK:       d.peak     = wr_data_i;
            `DSM_A_MAXCUR:     d.maxc     = wr_data_i;
            `DSM_A_MAX_SLIP:   d.max_slip = wr_data_i;
            `DSM_A_CTRL:       d.ctrl     = wr_data_i[2:0];
            default: ;
         endcase
      end
      // Overload accumulator, hardware update wins over a write
      d.active = ol_en;
      if (!q.active) begin
         d.calc = '0;
      end else if (q.tick) begin
         if (over_rated) begin
            d.calc = calc_sum[32] ? 32'hffff_ffff : calc_sum[31:0];
         end else begin
            d.calc = (q.calc > deficit) ? q.calc - deficit : '0;
         end
      end
      // Applied limit
      if (!q.active) begin
         d.limit = min_mp;
      end else if (q.ctrl[`DSM_CTRL_OPEN]) begin
         d.limit = min3;
      end else if ((q.calc > q.thr) || dur_done) begin
         d.limit = q.rated;
      end else begin
         d.limit = q.maxc;
      end
      // Slippage error history
      d.slip_prev = sp_done;
      d.elog      = sp_done && !q.slip_prev && q.ctrl[`DSM_CTRL_REACT];
      if (d.elog && (q.err_cnt != 16'hffff)) begin
         d.err_cnt = q.err_cnt + 16'h0001;
      end
      // Register reads
      d.rdata = '0;
      if (rd_i) begin
         case (addr_i)
            `DSM_A_BAND_HALFW: d.rdata = {16'h0000, q.halfw};
            `DSM_A_BAND_DWELL: d.rdata = {16'h0000, q.tdwell};
            `DSM_A_SLIP_DELAY: d.rdata = {16'h0000, q.sdelay};
            `DSM_A_RATED:      d.rdata = q.rated;
            `DSM_A_MAX_DUR:    d.rdata = q.dur;
            `DSM_A_THRESHOLD:  d.rdata = q.thr;
            `DSM_A_CALC:       d.rdata = q.calc;
            `DSM_A_LIMIT:      d.rdata = q.limit;
            `DSM_A_OL_STATUS:  d.rdata = {31'h0000_0000, q.active};
            `DSM_A_PEAK:       d.rdata = q.peak;
            `DSM_A_MAXCUR:     d.rdata = q.maxc;
            `DSM_A_MAX_SLIP:   d.rdata = q.max_slip;
            `DSM_A_CTRL:       d.rdata = {29'h0000_0000, q.ctrl};
            `DSM_A_STATUSWORD: d.rdata = {16'h0000, sw};
            `DSM_A_ERR_COUNT:  d.rdata = {16'h0000, q.err_cnt};
            default:           d.rdata = '0;
         endcase
      end
   end

   // ==========================================
   // State register
   always_ff @(posedge clock_i or negedge nrst_i) begin
      if (!nrst_i) begin
         q          <= '0;
         q.halfw    <= `DSM_BAND_RST;
         q.tdwell   <= `DSM_DWELL_RST;
         q.sdelay   <= `DSM_SLIP_DLY_RST;
         q.rated    <= `DSM_W32_RST;
         q.dur      <= `DSM_W32_RST;
         q.thr      <= `DSM_W32_RST;
         q.peak     <= `DSM_W32_RST;
         q.maxc     <= `DSM_W32_RST;
         q.max_slip <= `DSM_W32_RST;
      end else begin
         q <= d;
      end
   end

   assign rd_data_o        = q.rdata;
   assign current_limit_o  = q.limit;
   assign ol_active_o      = q.active;
   assign torque_reached_o = tq_done;
   assign slip_error_o     = sp_done;
   assign error_log_o      = q.elog;

   // ==========================================
   // Checks
   default clocking cb @(posedge clock_i); endclocking
   default disable iff (!nrst_i);

   a_active_gate: assert property (
      q.active |-> $past(q.rated < q.peak) && $past(q.rated < q.maxc))
      else $error("overload active with rated not below limits");
   a_enable_cond: assert property (
      q.active |-> $past(q.rated != '0 && q.dur != '0 && q.maxc > `DSM_MAXCUR_MIN))
      else $error("overload active without enable conditions");
   a_thresh_select: assert property (
      (q.active && !q.ctrl[`DSM_CTRL_OPEN] && q.calc > q.thr)
      |=> current_limit_o == $past(q.rated))
      else $error("limit not rated above threshold");
   a_open_min: assert property (
      (q.active && q.ctrl[`DSM_CTRL_OPEN]) |=> current_limit_o <= $past(q.rated)
      && current_limit_o <= $past(q.maxc) && current_limit_o <= $past(q.peak))
      else $error("open loop limit not the smallest");
   a_limit_read: assert property (
      (rd_i && addr_i == `DSM_A_LIMIT) |=> rd_data_o == $past(q.limit))
      else $error("limit read mismatch");
   a_status_read: assert property (
      (rd_i && addr_i == `DSM_A_OL_STATUS) |=> rd_data_o == {31'h0, $past(q.active)})
      else $error("status read mismatch");
   a_band_off: assert property (
      (q.halfw == `DSM_BAND_OFF) [*2] |-> !torque_reached_o)
      else $error("target reached with monitoring off");
   a_band_inside: assert property (
      torque_reached_o |-> $past(tq_in))
      else $error("target reached outside band");
   a_slip_vel: assert property (
      slip_error_o |-> $past(q.ctrl[`DSM_CTRL_VEL] && sp_abs > {1'b0, q.max_slip}))
      else $error("slip flagged without deviation");
   a_slip_log: assert property (
      error_log_o |-> $past(q.ctrl[`DSM_CTRL_REACT]) && $past(slip_error_o))
      else $error("error logged without reaction");

   a_tick_once: assert property (
      q.tick |=> !q.tick)
      else $error("tick longer than one cycle");

   a_tick_period: assert property (
      q.tick |-> $past(q.div) >= 16'(MS_CYCLES - 1))
      else $error("tick before divider end");

   a_idle_limit: assert property (
      !q.active |=> current_limit_o <= $past(q.maxc) && current_limit_o <= $past(q.peak)
      && (current_limit_o == $past(q.maxc) || current_limit_o == $past(q.peak)))
      else $error("inactive limit not min of max and peak");

   a_calc_clear: assert property (
      !q.active |=> q.calc == '0)
      else $error("computed value not cleared while inactive");

   a_calc_hold: assert property (
      (q.active && !q.tick && !(wr_i && addr_i == `DSM_A_CALC))
      |=> q.calc == $past(q.calc))
      else $error("computed value moved between ticks");

   a_calc_rise: assert property (
      (q.active && q.tick && over_rated) |=> q.calc >= $past(q.calc))
      else $error("computed value fell above rated current");

   a_calc_fall: assert property (
      (q.active && q.tick && !over_rated) |=> q.calc <= $past(q.calc))
      else $error("computed value rose below rated current");

   a_closed_max: assert property (
      (q.active && !q.ctrl[`DSM_CTRL_OPEN] && q.calc <= q.thr && !dur_done)
      |=> current_limit_o == $past(q.maxc))
      else $error("limit not max current below threshold");

   a_dur_limit: assert property (
      (q.active && !q.ctrl[`DSM_CTRL_OPEN] && dur_done)
      |=> current_limit_o == $past(q.rated))
      else $error("limit not rated after max current duration");

   a_enable_back: assert property (
      (q.rated != '0 && q.dur != '0 && q.maxc > `DSM_MAXCUR_MIN && q.rated < q.peak
      && q.rated < q.maxc) |=> ol_active_o)
      else $error("overload not active with enable conditions met");

   a_read_idle: assert property (
      !rd_i |=> rd_data_o == '0)
      else $error("read data not zero without read");

   a_sw_read: assert property (
      (rd_i && addr_i == `DSM_A_STATUSWORD)
      |=> rd_data_o[`DSM_SW_SLIP] == $past(slip_error_o)
      && rd_data_o[`DSM_SW_TREACH] == $past(torque_reached_o))
      else $error("statusword read mismatch");

   a_log_pulse: assert property (
      error_log_o |=> !error_log_o)
      else $error("error log pulse longer than one cycle");

   a_log_count: assert property (
      (error_log_o && $past(q.err_cnt) != 16'hffff)
      |-> q.err_cnt == $past(q.err_cnt) + 16'h0001)
      else $error("error count not advanced with log");
endmodule

// File: dsm_stage.sv
`timescale 1ns/1ps
// ==========================================
// Power stage model
module dsm_stage (
   input  wire logic        clock_i,
   input  wire logic        nrst_i,
   input  wire logic [31:0] demand_ma_i,
   input  wire logic [31:0] speed_cmd_i,
   input  wire logic [31:0] speed_dev_i,
   input  wire logic [15:0] torque_tgt_i,
   input  wire logic [15:0] torque_dev_i,
   output logic      [31:0] current_ma_o,
   output logic      [31:0] speed_act_o,
   output logic      [15:0] torque_act_o
);
   // Feedback lags demand by one cycle
   always_ff @(posedge clock_i or negedge nrst_i) begin
      if (!nrst_i) begin
         current_ma_o <= 32'h0;
         speed_act_o  <= 32'h0;
         torque_act_o <= 16'h0;
      end else begin
         current_ma_o <= demand_ma_i;
         speed_act_o  <= speed_cmd_i + speed_dev_i;
         torque_act_o <= torque_tgt_i + torque_dev_i;
      end
   end
endmodule

// File: drive_supervision_monitor_test.sv
`timescale 1ns/1ps
`include "dsm_map.svh"
module drive_supervision_monitor_test;
   localparam int MS = 8;
   logic        clock_i, nrst_i, wr_i, rd_i, e, ol_active_o;
   logic        torque_reached_o, slip_error_o, error_log_o;
   logic [15:0] addr_i, torque_tgt_i, torque_dev, torque_act, hw, dv;
   logic [31:0] wr_data_i, speed_cmd_i, speed_dev, demand, rd_data_o, rv, el;
   logic [31:0] current_limit_o, current_ma, speed_act;
   logic [31:0] c [4];
   logic [31:0] cfg [7][4] = '{'{32'h7d0, 32'h3e8, 32'hbb8, 32'hfa0},
      '{32'h3e8, 32'h5, 32'h3e8, 32'h1388}, '{32'h3e8, 32'h5, 32'h3e9, 32'h1388},
      '{32'h0, 32'h5, 32'hbb8, 32'hfa0}, '{32'h7d0, 32'h0, 32'hbb8, 32'hfa0},
      '{32'hfa0, 32'h5, 32'h1388, 32'hfa0}, '{32'hfa0, 32'h5, 32'h1388, 32'hfa1}};
   logic [15:0] td [4] = '{16'h6, 16'hfffa, 16'h5, 16'hfffb};
   logic [31:0] sc [4] = '{32'h5, 32'h4, 32'h1, 32'h5};
   logic [31:0] sd [4] = '{32'h32, 32'h33, 32'hffff_ffcd, 32'h33};
   logic [3:0]  se = 4'b1100;
   logic [3:0]  sl = 4'b1000;
   int          n_mismatch = 0;
   int          comparisons = 0;
   int          n_log = 0;
   int          n_base = 0;

   dsm_top #(.MS_CYCLES(MS)) u_dut (
      .clock_i(clock_i), .nrst_i(nrst_i), .addr_i(addr_i), .wr_data_i(wr_data_i),
      .wr_i(wr_i), .rd_i(rd_i), .rd_data_o(rd_data_o), .current_ma_i(current_ma),
      .torque_act_i(torque_act), .torque_tgt_i(torque_tgt_i), .speed_act_i(speed_act),
      .speed_cmd_i(speed_cmd_i), .current_limit_o(current_limit_o),
      .ol_active_o(ol_active_o), .torque_reached_o(torque_reached_o),
      .slip_error_o(slip_error_o), .error_log_o(error_log_o));
   dsm_stage u_stage (
      .clock_i(clock_i), .nrst_i(nrst_i), .demand_ma_i(demand), .speed_cmd_i(speed_cmd_i),
      .speed_dev_i(speed_dev), .torque_tgt_i(torque_tgt_i), .torque_dev_i(torque_dev),
      .current_ma_o(current_ma), .speed_act_o(speed_act), .torque_act_o(torque_act));

   // ==========================================
   // Clock, watchdog, helpers
   initial begin
      clock_i = 1'b0;
      forever #50 clock_i = ~clock_i;
   end
   initial begin
      #2000000;
      n_mismatch++;
      give_verdict();
   end
   always @(posedge clock_i) begin
      if (error_log_o === 1'b1) n_log++;
   end
   task automatic give_verdict();
      $display("Counts: n_mismatch=%0d comparisons=%0d", n_mismatch, comparisons);
      if (n_mismatch == 0 && comparisons > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         n_mismatch++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic chk_flag(input logic got, input logic exp);
      chk_word({31'h0, got}, {31'h0, exp});
   endtask
   task automatic wr_reg(input logic [15:0] a, input logic [31:0] d);
      @(posedge clock_i);
      addr_i    <= a;
      wr_data_i <= d;
      wr_i      <= 1'b1;
      @(posedge clock_i);
      wr_i <= 1'b0;
   endtask
   task automatic rd_reg(input logic [15:0] a, output logic [31:0] d);
      @(posedge clock_i);
      addr_i <= a;
      rd_i   <= 1'b1;
      @(posedge clock_i);
      rd_i <= 1'b0;
      #1;
      d = rd_data_o;
   endtask
   task automatic ms(input int n);
      repeat (n * MS) @(posedge clock_i);
      #1;
   endtask
   task automatic set_ol(input logic [31:0] r, d, m, p);
      wr_reg(`DSM_A_RATED, r);
      wr_reg(`DSM_A_MAX_DUR, d);
      wr_reg(`DSM_A_MAXCUR, m);
      wr_reg(`DSM_A_PEAK, p);
   endtask
   function automatic logic [31:0] min2(input logic [31:0] a, b);
      return (a < b) ? a : b;
   endfunction
   function automatic logic in_band(input logic [15:0] d, h);
      logic [15:0] m;
      m = d[15] ? -d : d;
      return m <= h;
   endfunction

   // ==========================================
   // Tests
   initial begin
      nrst_i = 1'b0;
      wr_i = 1'b0;
      rd_i = 1'b0;
      addr_i = 16'h0;
      wr_data_i = 32'h0;
      demand = 32'h0;
      speed_cmd_i = 32'h0;
      speed_dev = 32'h0;
      torque_tgt_i = 16'h0;
      torque_dev = 16'h0;
      rv = $urandom(32'hb654);
      repeat (3) @(posedge clock_i);
      nrst_i <= 1'b1;
      rd_reg(`DSM_A_BAND_HALFW, rv);
      chk_word(rv, 32'h0);
      rd_reg(`DSM_A_BAND_DWELL, rv);
      chk_word(rv, 32'h0);
      rd_reg(`DSM_A_SLIP_DELAY, rv);
      chk_word(rv, 32'h64);
      rd_reg(16'h2390, rv);
      chk_word(rv, 32'h0);
      // Overload enable and open loop limit
      for (int i = 0; i < 13; i++) begin
         if (i < 7) c = cfg[i];
         else c = '{$urandom_range(6000), $urandom_range(3), $urandom_range(6000, 900),
                    $urandom_range(6000)};
         set_ol(c[0], c[1], c[2], c[3]);
         wr_reg(`DSM_A_OL_STATUS, 32'h1);
         wr_reg(`DSM_A_CTRL, 32'h1 << `DSM_CTRL_OPEN);
         repeat (3) @(posedge clock_i);
         #1;
         e = c[0] != 0 && c[1] != 0 && c[2] > 32'h3e8 && c[0] < c[3] && c[0] < c[2];
         el = e ? min2(c[0], min2(c[2], c[3])) : min2(c[2], c[3]);
         chk_flag(ol_active_o, e);
         rd_reg(`DSM_A_OL_STATUS, rv);
         chk_word(rv, {31'h0, e});
         chk_word(current_limit_o, el);
         rd_reg(`DSM_A_LIMIT, rv);
         chk_word(rv, el);
      end
      // Closed loop duration and threshold
      set_ol(32'h7d0, 32'h3, 32'hbb8, 32'hfa0);
      wr_reg(`DSM_A_THRESHOLD, 32'hffff_ffff);
      wr_reg(`DSM_A_CTRL, 32'h0);
      demand <= 32'h9c4;
      repeat (4) @(posedge clock_i);
      #1;
      chk_word(current_limit_o, 32'hbb8);
      ms(5);
      chk_word(current_limit_o, 32'h7d0);
      @(posedge clock_i);
      demand <= 32'h3e8;
      ms(4);
      chk_word(current_limit_o, 32'hbb8);
      wr_reg(`DSM_A_MAX_DUR, 32'h3e8);
      wr_reg(`DSM_A_THRESHOLD, 32'hfa);
      demand <= 32'h834;
      ms(1);
      chk_word(current_limit_o, 32'hbb8);
      ms(5);
      chk_word(current_limit_o, 32'h7d0);
      rd_reg(`DSM_A_CALC, rv);
      chk_flag(rv > 32'hfa, 1'b1);
      // Torque band and dwell
      wr_reg(`DSM_A_BAND_DWELL, 32'h3);
      for (int i = 0; i < 8; i++) begin
         hw = (i < 4) ? 16'h5 : 16'($urandom_range(200, 1));
         dv = (i < 4) ? td[i] : 16'($urandom_range(2 * hw + 2)) - hw - 16'h1;
         wr_reg(`DSM_A_BAND_HALFW, {16'h0, hw});
         rd_reg(`DSM_A_BAND_HALFW, rv);
         chk_word(rv, {16'h0, hw});
         @(posedge clock_i);
         torque_tgt_i <= 16'($urandom_range(20000)) - 16'h2710;
         torque_dev   <= hw + 16'h1;
         ms(1);
         chk_flag(torque_reached_o, 1'b0);
         @(posedge clock_i);
         torque_dev <= dv;
         ms(1);
         chk_flag(torque_reached_o, 1'b0);
         ms(4);
         chk_flag(torque_reached_o, in_band(dv, hw));
      end
      rd_reg(`DSM_A_STATUSWORD, rv);
      chk_flag(rv[`DSM_SW_TREACH], in_band(dv, hw));
      wr_reg(`DSM_A_BAND_HALFW, 32'hffff);
      torque_dev <= 16'h0;
      ms(5);
      chk_flag(torque_reached_o, 1'b0);
      // Slippage detection and logging
      wr_reg(`DSM_A_MAX_SLIP, 32'h32);
      wr_reg(`DSM_A_SLIP_DELAY, 32'h3);
      for (int i = 0; i < 4; i++) begin
         @(posedge clock_i);
         speed_dev   <= 32'h0;
         speed_cmd_i <= $urandom_range(100000);
         ms(1);
         wr_reg(`DSM_A_CTRL, sc[i]);
         n_base = n_log;
         speed_dev <= sd[i];
         ms(2);
         chk_flag(slip_error_o, 1'b0);
         ms(5);
         chk_flag(slip_error_o, se[i]);
         chk_word(32'(n_log - n_base), {31'h0, sl[i]});
      end
      rd_reg(`DSM_A_ERR_COUNT, rv);
      chk_word(rv, 32'h1);
      rd_reg(`DSM_A_STATUSWORD, rv);
      chk_flag(rv[`DSM_SW_SLIP], 1'b1);
      give_verdict();
   end
endmodule
